// [core/pifmu_pkg.sv]
// Purpose: constants for the peripheral interrupt flag and mask unit
// Assumes: 4-bit I/O data bus, 16-bit I/O addresses
// Notes: mask registers at FFE1..FFE7, event flags at FFF1..FFF7
package pifmu_pkg;
  localparam logic [15:0] ADDR_MASK_PT = 16'hFFE1;
  localparam logic [15:0] ADDR_MASK_SIO = 16'hFFE2;
  localparam logic [15:0] ADDR_MASK_K0 = 16'hFFE3;
  localparam logic [15:0] ADDR_MASK_K1 = 16'hFFE4;
  localparam logic [15:0] ADDR_MASK_CT = 16'hFFE5;
  localparam logic [15:0] ADDR_MASK_SW = 16'hFFE6;
  localparam logic [15:0] ADDR_MASK_RF = 16'hFFE7;
  localparam logic [15:0] ADDR_FLAG_PT = 16'hFFF1;
  localparam logic [15:0] ADDR_FLAG_SIO = 16'hFFF2;
  localparam logic [15:0] ADDR_FLAG_K0 = 16'hFFF3;
  localparam logic [15:0] ADDR_FLAG_K1 = 16'hFFF4;
  localparam logic [15:0] ADDR_FLAG_CT = 16'hFFF5;
  localparam logic [15:0] ADDR_FLAG_SW = 16'hFFF6;
  localparam logic [15:0] ADDR_FLAG_RF = 16'hFFF7;
  // Group index: low three bits of the register address
  localparam int GRP_PT = 1;
  localparam int GRP_SIO = 2;
  localparam int GRP_K0 = 3;
  localparam int GRP_K1 = 4;
  localparam int GRP_CT = 5;
  localparam int GRP_SW = 6;
  localparam int GRP_RF = 7;
  localparam int NUM_GRP = 8;
  // Implemented bits per group; unimplemented bits have no storage
  localparam logic [3:0] BITS_PT = 4'h7;
  localparam logic [3:0] BITS_SIO = 4'h1;
  localparam logic [3:0] BITS_K0 = 4'h1;
  localparam logic [3:0] BITS_K1 = 4'h1;
  localparam logic [3:0] BITS_CT = 4'hF;
  localparam logic [3:0] BITS_SW = 4'hF;
  localparam logic [3:0] BITS_RF = 4'h3;
  // Field positions
  localparam int CT_1HZ_BIT = 3;
  localparam int CT_2HZ_BIT = 2;
  localparam int CT_8HZ_BIT = 1;
  localparam int CT_32HZ_BIT = 0;
  localparam int SW_RUN_BIT = 3;
  localparam int SW_LAP_BIT = 2;
  localparam int SW_1HZ_BIT = 1;
  localparam int SW_10HZ_BIT = 0;
  localparam int RF_REF_BIT = 1;
  localparam int RF_SENSOR_BIT = 0;
  localparam logic [3:0] FLAG_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // Vectors 0100H..010EH, low nibble comes from the source
  localparam logic [15:0] VECTOR_BASE = 16'h0100;
  localparam logic [3:0] VEC_WDT = 4'h0;
  localparam logic [3:0] VEC_RF = 4'h2;
  localparam logic [3:0] VEC_PT = 4'h4;
  localparam logic [3:0] VEC_SIO = 4'h6;
  localparam logic [3:0] VEC_K0 = 4'h8;
  localparam logic [3:0] VEC_K1 = 4'hA;
  localparam logic [3:0] VEC_CT = 4'hC;
  localparam logic [3:0] VEC_SW = 4'hE;
endpackage : pifmu_pkg

// [core/pifmu_stack_gate.sv]
// Purpose: blocks all interrupts until both stack pointers are written
// Assumes: core pulses one strobe per stack pointer write
// Notes: rewriting one pointer reopens the pair
`timescale 1ns/1ps
`default_nettype none
module pifmu_stack_gate (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Stack pointer write strobes
  input wire logic wide_sp_write,
  input wire logic nibble_sp_write,
  // Acceptance gate
  output logic irq_allowed
);
  typedef struct packed {
    logic wide_done;
    logic nibble_done;
  } pifmu_gate_s;

  pifmu_gate_s st;
  pifmu_gate_s next_st;

  always_comb begin
    next_st = st;
    if (wide_sp_write && nibble_sp_write) begin
      next_st.wide_done = 1'b1;
      next_st.nibble_done = 1'b1;
    end else if (wide_sp_write) begin
      // Pair already complete: this write starts a new pair
      if (st.wide_done && st.nibble_done) begin
        next_st.nibble_done = 1'b0;
      end
      next_st.wide_done = 1'b1;
    end else if (nibble_sp_write) begin
      if (st.wide_done && st.nibble_done) begin
        next_st.wide_done = 1'b0;
      end
      next_st.nibble_done = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign irq_allowed = st.wide_done & st.nibble_done;
endmodule : pifmu_stack_gate
`default_nettype wire

// [core/pifmu_unit.sv]
// Purpose: peripheral interrupt flags, masks, request and vector
// Assumes: 4-bit I/O bus, single-cycle read and write strobes
// Notes: event inputs are one-cycle pulses from the peripherals
//
// Summary of operation
// - Flags latch on their event whatever the mask bit holds.
// - Flags read 1 while pending; writing 1 clears, writing 0 keeps.
// - Request stays high while any enabled flag remains set.
// - Clock timer flags: 1 Hz bit 3, 2 Hz, 8 Hz, 32 Hz bit 0.
// - Stopwatch flags: run bit 3, lap bit 2, 1 Hz, 10 Hz bit 0.
// - Converter flags: reference bit 1, sensor bit 0, bits 3-2 unused.
// - Three programmable timer enables and flags in bits 2 to 0.
// - Serial and both key groups use bit 0 of own registers.
// - Clock timer and stopwatch masks are full four-bit registers.
// - Converter masks in bits 1 and 0 pair with their flags.
// - Initial reset clears every event flag.
// - Unused bits have no storage, read 0, ignore writes.
// - After reset, all interrupts blocked until both stack pointers written.
// - Rewriting one pointer blocks interrupts until the other follows.
// - Mask bits read/write, reset 0; 1 enables, 0 inhibits.
// - Acceptance saves flags, clears enable, pushes PC, loads vector.
// - Vectors 0100H to 010EH by step two, watchdog highest priority.
`timescale 1ns/1ps
`default_nettype none
module pifmu_unit
  import pifmu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // I/O memory bus from the core
  input wire logic [15:0] io_addr,
  input wire logic io_read,
  input wire logic io_write,
  input wire logic [3:0] io_wdata,
  output logic [3:0] io_rdata,
  output logic io_hit,
  // Stack pointer write strobes from the core
  input wire logic wide_stack_pointer_write,
  input wire logic nibble_stack_pointer_write,
  // Peripheral event pulses
  input wire logic [2:0] prog_timer_event,
  input wire logic serial_event,
  input wire logic key_group0_event,
  input wire logic key_group1_event,
  input wire logic tick_1hz_event,
  input wire logic tick_2hz_event,
  input wire logic tick_8hz_event,
  input wire logic tick_32hz_event,
  input wire logic sw_run_input_event,
  input wire logic sw_lap_input_event,
  input wire logic sw_one_hz_event,
  input wire logic sw_ten_hz_event,
  input wire logic rf_reference_done_event,
  input wire logic rf_sensor_done_event,
  // Non-maskable request from the watchdog
  input wire logic watchdog_nmi,
  // Request to the core
  output logic irq_request,
  output logic nmi_request,
  output logic [15:0] irq_vector
);
  typedef struct packed {
    logic [NUM_GRP-1:0][3:0] flags;
    logic [NUM_GRP-1:0][3:0] masks;
    logic [3:0] rdata;
    logic hit;
    logic [15:0] vector;
  } pifmu_state_s;

  pifmu_state_s st;
  pifmu_state_s next_st;
  logic irq_allowed;
  logic [NUM_GRP-1:0][3:0] events;
  logic [NUM_GRP-1:0][3:0] impl_bits;
  logic [NUM_GRP-1:0] grp_req;

  pifmu_stack_gate u_stack_gate (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wide_sp_write(wide_stack_pointer_write),
    .nibble_sp_write(nibble_stack_pointer_write),
    .irq_allowed(irq_allowed)
  );

  // Event and implemented-bit maps per group
  always_comb begin
    events = '0;
    impl_bits = '0;
    events[GRP_PT] = {1'b0, prog_timer_event};
    events[GRP_SIO][0] = serial_event;
    events[GRP_K0][0] = key_group0_event;
    events[GRP_K1][0] = key_group1_event;
    events[GRP_CT][CT_1HZ_BIT] = tick_1hz_event;
    events[GRP_CT][CT_2HZ_BIT] = tick_2hz_event;
    events[GRP_CT][CT_8HZ_BIT] = tick_8hz_event;
    events[GRP_CT][CT_32HZ_BIT] = tick_32hz_event;
    events[GRP_SW][SW_RUN_BIT] = sw_run_input_event;
    events[GRP_SW][SW_LAP_BIT] = sw_lap_input_event;
    events[GRP_SW][SW_1HZ_BIT] = sw_one_hz_event;
    events[GRP_SW][SW_10HZ_BIT] = sw_ten_hz_event;
    events[GRP_RF][RF_REF_BIT] = rf_reference_done_event;
    events[GRP_RF][RF_SENSOR_BIT] = rf_sensor_done_event;
    impl_bits[GRP_PT] = BITS_PT;
    impl_bits[GRP_SIO] = BITS_SIO;
    impl_bits[GRP_K0] = BITS_K0;
    impl_bits[GRP_K1] = BITS_K1;
    impl_bits[GRP_CT] = BITS_CT;
    impl_bits[GRP_SW] = BITS_SW;
    impl_bits[GRP_RF] = BITS_RF;
  end

  // Group requests: any flag with its matching mask bit
  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g++) begin : g_req
      assign grp_req[g] = |(st.flags[g] & st.masks[g]);
    end
  endgenerate

  logic mask_sel;
  logic flag_sel;
  logic [2:0] grp_idx;

  always_comb begin
    next_st = st;
    mask_sel = (io_addr >= ADDR_MASK_PT) && (io_addr <= ADDR_MASK_RF);
    flag_sel = (io_addr >= ADDR_FLAG_PT) && (io_addr <= ADDR_FLAG_RF);
    grp_idx = io_addr[2:0];
    // Flags: event set wins over a same-cycle clear
    for (int i = 0; i < NUM_GRP; i++) begin
      if (io_write && flag_sel && grp_idx == i[2:0]) begin
        next_st.flags[i] = st.flags[i] & ~io_wdata;
      end
      next_st.flags[i] = (next_st.flags[i] | events[i]) & impl_bits[i];
      if (io_write && mask_sel && grp_idx == i[2:0]) begin
        next_st.masks[i] = io_wdata & impl_bits[i];
      end
    end
    // Registered read data; unused bits read 0
    next_st.hit = (io_read || io_write) && (mask_sel || flag_sel);
    next_st.rdata = 4'h0;
    if (io_read && mask_sel) begin
      next_st.rdata = st.masks[grp_idx] & impl_bits[grp_idx];
    end else if (io_read && flag_sel) begin
      next_st.rdata = st.flags[grp_idx] & impl_bits[grp_idx];
    end
    // Fixed priority vector, watchdog first
    if (watchdog_nmi) begin
      next_st.vector = VECTOR_BASE | {12'h000, VEC_WDT};
    end else if (grp_req[GRP_RF]) begin
      next_st.vector = VECTOR_BASE | {12'h000, VEC_RF};
    end else if (grp_req[GRP_PT]) begin
      next_st.vector = VECTOR_BASE | {12'h000, VEC_PT};
    end else if (grp_req[GRP_SIO]) begin
      next_st.vector = VECTOR_BASE | {12'h000, VEC_SIO};
    end else if (grp_req[GRP_K0]) begin
      next_st.vector = VECTOR_BASE | {12'h000, VEC_K0};
    end else if (grp_req[GRP_K1]) begin
      next_st.vector = VECTOR_BASE | {12'h000, VEC_K1};
    end else if (grp_req[GRP_CT]) begin
      next_st.vector = VECTOR_BASE | {12'h000, VEC_CT};
    end else if (grp_req[GRP_SW]) begin
      next_st.vector = VECTOR_BASE | {12'h000, VEC_SW};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st.flags <= {NUM_GRP{FLAG_RESET}};
      st.masks <= {NUM_GRP{MASK_RESET}};
      st.rdata <= 4'h0;
      st.hit <= 1'b0;
      st.vector <= VECTOR_BASE;
    end else begin
      st <= next_st;
    end
  end

  // Level request; the core clears its own enable on acceptance
  assign irq_request = irq_allowed & (|grp_req);
  assign nmi_request = irq_allowed & watchdog_nmi;
  assign irq_vector = st.vector;
  assign io_rdata = st.rdata;
  assign io_hit = st.hit;
endmodule : pifmu_unit
`default_nettype wire

// [tb/pifmu_unit_assertions.sv]
// Purpose: port checks for the interrupt flag and mask unit
// Assumes: bound into pifmu_unit
// Notes: sp_w, sp_n mark pointer writes since reset
`timescale 1ns/1ps
`default_nettype none
module pifmu_unit_assertions (
  // Clock, reset, bus
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [15:0] io_addr,
  input wire logic io_read,
  input wire logic [3:0] io_rdata,
  input wire logic io_hit,
  // Pointers and requests
  input wire logic wide_stack_pointer_write,
  input wire logic nibble_stack_pointer_write,
  input wire logic irq_request,
  input wire logic nmi_request,
  input wire logic [15:0] irq_vector
);
  logic sp_w, sp_n;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n) {sp_w, sp_n} <= 2'b00;
    else {sp_w, sp_n} <= {sp_w | wide_stack_pointer_write,
      sp_n | nibble_stack_pointer_write};
  irq_gate_a: assert property (irq_request |-> sp_w && sp_n)
    else $error("early request");
  nmi_gate_a: assert property (nmi_request |-> sp_w && sp_n)
    else $error("early nmi");
  nmi_vector_a: assert property (nmi_request [*2] |=>
    irq_vector == 16'h0100) else $error("nmi vector");
  vector_form_a: assert property (irq_vector[15:4] == 12'h010
    && !irq_vector[0]) else $error("vector range");
  unmapped_read_a: assert property (io_read && io_addr[15:8] != 8'hFF
    |=> !io_hit && io_rdata == 4'h0) else $error("unmapped read");
  rf_unused_a: assert property (io_read && io_addr == 16'hFFF7
    |=> io_rdata[3:2] == 2'b00) else $error("converter bits");
  key_unused_a: assert property (io_read && io_addr == 16'hFFE3
    |=> io_rdata[3:1] == 3'b000) else $error("key mask bits");
  flag_hit_a: assert property (io_read && io_addr == 16'hFFF5
    |=> io_hit) else $error("flag read missed");
  cover property ($rose(irq_request));
  cover property (nmi_request);
  cover property (io_read && io_addr[15:8] != 8'hFF);
endmodule : pifmu_unit_assertions
`default_nettype wire

// [tb/pifmu_core_model.sv]
// Purpose: core model driving the I/O bus and pointer strobes
// Assumes: one-cycle strobes, read data after the read edge
// Notes: write data idles inverted
`timescale 1ns/1ps
`default_nettype none
module pifmu_core_model (
  // Clock and read data
  input wire logic clk_sys,
  input wire logic [3:0] io_rdata,
  // Bus and pointer strobes
  output logic [15:0] io_addr = 16'h0000,
  output logic io_read = 1'b0,
  output logic io_write = 1'b0,
  output logic [3:0] io_wdata = 4'h0,
  output logic wide_stack_pointer_write = 1'b0,
  output logic nibble_stack_pointer_write = 1'b0
);
  // k: nibble pointer, wide pointer, write, read
  task automatic xfer(input logic [3:0] k, input logic [15:0] a,
    input logic [3:0] v, output logic [3:0] d);
    @(posedge clk_sys);
    {nibble_stack_pointer_write, wide_stack_pointer_write} <= k[3:2];
    {io_write, io_read} <= k[1:0];
    io_addr <= a;
    io_wdata <= v;
    @(posedge clk_sys);
    {nibble_stack_pointer_write, wide_stack_pointer_write} <= 2'b00;
    {io_write, io_read} <= 2'b00;
    io_wdata <= ~v;
    #1;
    d = io_rdata;
  endtask : xfer
endmodule : pifmu_core_model
`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench for the interrupt flag and mask unit
// Assumes: core model owns bus and pointer strobes
// Notes: masks stay open from t_masks until the mid-run reset
`timescale 1ns/1ps
`default_nettype none
module tb import pifmu_pkg::*; ;
  logic clk_sys, reset_n = 1'b0, watchdog_nmi = 1'b0, io_read, io_write;
  logic io_hit, irq_request, nmi_request;
  logic wide_stack_pointer_write, nibble_stack_pointer_write;
  logic [15:0] io_addr, irq_vector, g, ev = 16'h0000;
  logic [3:0] io_wdata, io_rdata, d;
  int fail_count, total_checks, cycles, b;
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] k, input logic [15:0] a,
    input logic [3:0] v);
    pifmu_core_model_i.xfer(k, a, v, d);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [3:0] e);
    wr(4'h1, a, 4'h0);
    chk(d, e);
    chk(io_hit, a[15:5] == 11'h7FF && a[2:0] != 3'h0 && !a[3]);
  endtask : rd
  task automatic pulse(input logic [15:0] v);
    @(posedge clk_sys);
    ev <= v;
    @(posedge clk_sys);
    ev <= 16'h0000;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : pulse
  task automatic t_events();
    for (int i = 0; i < 16; i++) begin
      g = 16'(i < 3 ? 1 : i < 6 ? i - 1 : i < 10 ? 5 : i < 14 ? 6 : 7);
      b = i < 3 ? i : i < 6 ? 0 : (i - 6) % 4;
      pulse(16'h1 << i);
      chk(irq_request, 1'b0);
      rd(16'hFFF0 | g, 4'h1 << b);
      wr(4'h2, 16'hFFF0 | g, ~(4'h1 << b));
      rd(16'hFFF0 | g, 4'h1 << b);
      wr(4'h2, 16'hFFF0 | g, 4'h1 << b);
      rd(16'hFFF0 | g, 4'h0);
    end
  endtask : t_events
  task automatic t_masks();
    rd(16'h0000, 4'h0);
    for (g = 1; g < 8; g++) begin
      rd(16'hFFE0 | g, MASK_RESET);
      wr(4'h2, 16'hFFE0 | g, 4'hF);
      rd(16'hFFE0 | g, g == 1 ? BITS_PT : g < 5 ? BITS_SIO : g < 7 ?
        BITS_CT : BITS_RF);
    end
  endtask : t_masks
  task automatic t_requests();
    pulse(16'hFFFF);
    @(posedge clk_sys);
    watchdog_nmi <= 1'b1;
    wr(4'h4, 16'h0000, 4'h0);
    pulse(16'h0000);
    chk({irq_request, nmi_request}, 2'b00);
    wr(4'h8, 16'h0000, 4'h0);
    pulse(16'h0000);
    chk({irq_request, nmi_request}, 2'b11);
    chk(irq_vector, VECTOR_BASE);
    wr(4'h4, 16'h0000, 4'h0);
    pulse(16'h0000);
    chk({irq_request, nmi_request}, 2'b00);
    @(posedge clk_sys);
    watchdog_nmi <= 1'b0;
    wr(4'h8, 16'h0000, 4'h0);
    pulse(16'h0000);
    for (g = 0; g < 7; g++) begin
      chk(irq_request, 1'b1);
      chk(irq_vector, VECTOR_BASE + 16'(2 * g + 2));
      wr(4'h2, 16'hFFF0 | (g == 0 ? 16'h7 : g), 4'hF);
      pulse(16'h0000);
    end
    chk(irq_request, 1'b0);
  endtask : t_requests
  // Event and clear on one edge, then a reset in mid-run
  task automatic t_collide_reset();
    fork
      pulse(16'h0040);
      wr(4'h2, 16'hFFF5, 4'h1);
    join
    rd(16'hFFF5, 4'h1);
    chk(irq_request, 1'b1);
    chk(irq_vector, VECTOR_BASE + 16'h000C);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    chk({irq_request, nmi_request}, 2'b00);
    chk(irq_vector, VECTOR_BASE);
    rd(16'hFFF5, FLAG_RESET);
    rd(16'hFFE5, MASK_RESET);
    wr(4'h2, 16'hFFE5, 4'hF);
    pulse(16'h0040);
    chk(irq_request, 1'b0);
    rd(16'hFFF5, 4'h1);
  endtask : t_collide_reset
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_events();
    t_masks();
    t_requests();
    t_collide_reset();
    summarize();
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  pifmu_unit pifmu_unit_i (.*, .prog_timer_event(ev[2:0]),
    .serial_event(ev[3]), .key_group0_event(ev[4]),
    .key_group1_event(ev[5]), .tick_32hz_event(ev[6]),
    .tick_8hz_event(ev[7]), .tick_2hz_event(ev[8]),
    .tick_1hz_event(ev[9]), .sw_ten_hz_event(ev[10]),
    .sw_one_hz_event(ev[11]), .sw_lap_input_event(ev[12]),
    .sw_run_input_event(ev[13]), .rf_sensor_done_event(ev[14]),
    .rf_reference_done_event(ev[15]));
  pifmu_core_model pifmu_core_model_i (.*);
endmodule : tb
bind pifmu_unit pifmu_unit_assertions pifmu_unit_assertions_i (.*);
`default_nettype wire
